// ### hdl/lhb_regs.svh
// constants of the host bus interface: pin positions and counts
`ifndef LHB_REGS_SVH
`define LHB_REGS_SVH
`define LHB_BYTE_W 8
`define LHB_PIN_W 15
`define LHB_SI_BIT 7
`define LHB_SCL_BIT 6
`define LHB_P_CDS 8
`define LHB_P_WR 9
`define LHB_P_RD 10
`define LHB_P_CS 11
`define LHB_P_INIT 12
`define LHB_P_STRB 13
`define LHB_P_PS 14
`define LHB_BIT_LAST 3'h7
`define LHB_BIT_ZERO 3'h0
`define LHB_BIT_ONE 3'h1
`define LHB_BYTE_ZERO 8'h00
`define LHB_PIN_IDLE 15'h5eff
`endif

// ### hdl/lhb_pkg.sv
// types of the host bus interface
`default_nettype none
package lhb_pkg;
  typedef enum logic [1:0] {
    LHB_SERIAL = 2'b00,
    LHB_SPLIT = 2'b01,
    LHB_ENABLE = 2'b10
  } lhb_mode_t;
endpackage : lhb_pkg
`default_nettype wire

// ### hdl/lhb_host_bus.sv
// device side of the display controller host bus interface
`timescale 1ns/1ns
`default_nettype none
`include "lhb_regs.svh"
module lhb_host_bus
  import lhb_pkg::*;
#(
  parameter int DATA_W = `LHB_BYTE_W
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic rd_pin,
  input wire logic wr_pin,
  input wire logic cmd_data_sel,
  input wire logic chip_sel_n,
  input wire logic init_low,
  input wire logic ser_par_sel,
  input wire logic strobe_mode,
  input wire logic [DATA_W-1:0] rd_byte,
  output logic rd_take,
  output logic [DATA_W-1:0] rx_byte,
  output logic rx_is_data,
  output logic rx_valid,
  output logic init_active
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (DATA_W != `LHB_BYTE_W) begin : g_bad_width
    $error("data width must be eight");
  end

  function automatic logic fn_rise(input logic cur, input logic prev);
    fn_rise = cur & ~prev;
  endfunction : fn_rise

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // s1 feeds s2 only; s3 holds the previous sample for edges and data
  logic [`LHB_PIN_W-1:0] s1_r;
  logic [`LHB_PIN_W-1:0] s2_r;
  logic [`LHB_PIN_W-1:0] s3_r;
  wire [`LHB_PIN_W-1:0] pins_w = {ser_par_sel, strobe_mode, init_low, chip_sel_n,
                                  rd_pin, wr_pin, cmd_data_sel, data_in};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_r <= `LHB_PIN_IDLE;
      s2_r <= `LHB_PIN_IDLE;
      s3_r <= `LHB_PIN_IDLE;
    end else begin
      s1_r <= pins_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  lhb_mode_t mode;
  assign mode = !s2_r[`LHB_P_PS] ? LHB_SERIAL :
                (s2_r[`LHB_P_STRB] ? LHB_ENABLE : LHB_SPLIT);
  wire dev_rst = srst | ~s2_r[`LHB_P_INIT];
  wire cs_act = ~s2_r[`LHB_P_CS];
  wire [DATA_W-1:0] bus_prev = s3_r[DATA_W-1:0];
  wire cd_prev = s3_r[`LHB_P_CDS];
  wire rd_s = s2_r[`LHB_P_RD];
  wire rw_s = s2_r[`LHB_P_WR];
  wire rw_prev = s3_r[`LHB_P_WR];
  wire is_ser = (mode == LHB_SERIAL);
  wire is_split = (mode == LHB_SPLIT);
  wire is_en = (mode == LHB_ENABLE);
  wire scl_rise = fn_rise(s2_r[`LHB_SCL_BIT], s3_r[`LHB_SCL_BIT]);
  wire wr_rise = fn_rise(s2_r[`LHB_P_WR], s3_r[`LHB_P_WR]);
  wire rd_rise = fn_rise(rd_s, s3_r[`LHB_P_RD]);
  // enable falls to end a transfer
  wire e_fall = fn_rise(s3_r[`LHB_P_RD], rd_s);

  // ----------------------------------------
  // serial shifter
  // ----------------------------------------
  logic [DATA_W-1:0] sh_r;
  logic [2:0] bit_r;
  // msb first, previous sample avoids hold risk
  wire [DATA_W-1:0] sh_nxt = {sh_r[DATA_W-2:0], bus_prev[`LHB_SI_BIT]};
  wire ser_step = is_ser & cs_act & scl_rise;
  wire ser_done = ser_step & (bit_r == `LHB_BIT_LAST);
  // count restarts whenever chip select drops away
  wire [2:0] bit_nxt = (!cs_act || !is_ser) ? `LHB_BIT_ZERO :
                       (ser_step ? bit_r + `LHB_BIT_ONE : bit_r);

  // ----------------------------------------
  // write capture and read drive
  // ----------------------------------------
  // split write on strobe rising edge
  wire par_wr = is_split & cs_act & wr_rise;
  // direction low writes, latched as enable falls
  wire en_wr = is_en & cs_act & e_fall & ~rw_prev;
  wire any_wr = par_wr | en_wr | ser_done;
  wire [DATA_W-1:0] rx_nxt = ser_done ? sh_nxt : bus_prev;
  // split read strobe low drives the bus
  // enable high with direction high drives the bus
  wire oe_nxt = cs_act & ((is_split & ~rd_s) | (is_en & rd_s & rw_s));
  wire take_nxt = cs_act & ((is_split & rd_rise) | (is_en & e_fall & rw_prev));

  logic [DATA_W-1:0] data_out_r;
  logic data_oe_r;
  logic rd_take_r;
  logic [DATA_W-1:0] rx_byte_r;
  logic rx_is_data_r;
  logic rx_valid_r;
  logic init_active_r;

  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      sh_r <= `LHB_BYTE_ZERO;
      bit_r <= `LHB_BIT_ZERO;
      rx_byte_r <= `LHB_BYTE_ZERO;
      rx_is_data_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rd_take_r <= 1'b0;
      data_oe_r <= 1'b0;
    end else begin
      sh_r <= ser_step ? sh_nxt : sh_r;
      bit_r <= bit_nxt;
      rx_valid_r <= any_wr;
      rd_take_r <= take_nxt;
      data_oe_r <= oe_nxt;
      if (any_wr) begin
        rx_byte_r <= rx_nxt;
        // command/data flag travels with the byte
        rx_is_data_r <= cd_prev;
      end
    end
  end

  // read byte follows the core; it only reaches the pins with data_oe
  // byte wide two-way path
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_out_r <= `LHB_BYTE_ZERO;
      init_active_r <= 1'b1;
    end else begin
      data_out_r <= rd_byte;
      init_active_r <= ~s2_r[`LHB_P_INIT];
    end
  end

  assign data_out = data_out_r;
  assign data_oe = data_oe_r;
  assign rd_take = rd_take_r;
  assign rx_byte = rx_byte_r;
  assign rx_is_data = rx_is_data_r;
  assign rx_valid = rx_valid_r;
  assign init_active = init_active_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  cs_release_a: assert property (!cs_act |=> !data_oe_r)
    else $error("data bus driven while deselected");
  serial_nodrive_a: assert property (is_ser |=> !data_oe_r)
    else $error("data bus driven in serial mode");
  split_read_a: assert property (
    !dev_rst && is_split && cs_act && !rd_s |=> data_oe_r)
    else $error("split read not driving bus");
  split_write_a: assert property (
    !dev_rst && par_wr |=> rx_valid_r && rx_byte_r == $past(bus_prev))
    else $error("split write byte lost");
  enable_write_a: assert property (
    !dev_rst && en_wr |=> rx_valid_r && rx_byte_r == $past(bus_prev))
    else $error("enable write byte lost");
  en_dir_a: assert property (
    !dev_rst && is_en && cs_act && rd_s |=> data_oe_r == $past(rw_s))
    else $error("enable direction wrong");
  read_follow_a: assert property (
    !$past(srst) |-> data_out_r == $past(rd_byte))
    else $error("read byte not following core");
  cd_flag_a: assert property (rx_valid_r |-> rx_is_data_r == $past(cd_prev))
    else $error("command/data flag mismatch");
  cs_accept_a: assert property (rx_valid_r |-> $past(cs_act))
    else $error("byte taken without chip select");
  init_hold_a: assert property (
    !s2_r[`LHB_P_INIT] |=> !rx_valid_r && bit_r == `LHB_BIT_ZERO && init_active_r)
    else $error("init level not resetting");
  // eighth serial edge delivers shifted byte
  serial_byte_a: assert property (
    !dev_rst && ser_done |=> rx_valid_r && rx_byte_r == $past(sh_nxt)
    && bit_r == `LHB_BIT_ZERO)
    else $error("serial byte wrong");

endmodule : lhb_host_bus
`default_nettype wire

// ### tb/lhb_host_model.sv
// host model driving the controller pins
`timescale 1ns/1ns
`default_nettype none
module lhb_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic strobe_mode,
  output logic [7:0] data_in,
  output logic rd_pin,
  output var logic wr_pin = 1'b1,
  output var logic cmd_data_sel = 1'b0,
  output var logic chip_sel_n = 1'b1
);
  logic [7:0] drv = 8'hff;
  logic hoe = 1'b0;
  logic ra = 1'b0;
  logic ea = 1'b0;
  // shared bus, released lines pulled high
  assign data_in = data_oe ? data_out : (hoe ? drv : 8'hff);
  // enable high only inside a transfer
  assign rd_pin = strobe_mode ? (ra | ea) : ~ra;
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : hold
  // data held across the closing strobe edge
  task automatic wr(input logic [7:0] b, input logic cd, input logic cs);
    hold(1);
    drv = b;
    hoe = 1'b1;
    cmd_data_sel = cd;
    chip_sel_n = cs;
    wr_pin = 1'b0;
    ea = strobe_mode;
    hold(20);
    ea = 1'b0;
    wr_pin = ~strobe_mode;
    hold(20);
    hoe = 1'b0;
    wr_pin = 1'b1;
    chip_sel_n = 1'b1;
  endtask : wr
  // read sampled late in the strobe
  task automatic rd(input logic cd, input logic cs, output logic [7:0] s);
    hold(1);
    cmd_data_sel = cd;
    chip_sel_n = cs;
    ra = 1'b1;
    hold(20);
    s = data_in;
    ra = 1'b0;
    hold(20);
    chip_sel_n = 1'b1;
  endtask : rd
  // msb first, unused bits high, clock idle high
  task automatic ser(input logic [7:0] b, input logic cd, input int n);
    hold(1);
    hoe = 1'b1;
    chip_sel_n = 1'b0;
    cmd_data_sel = cd;
    for (int i = 7; i > 7 - n; i--) begin
      drv = {b[i], 1'b0, 6'h3f};
      hold(10);
      drv[6] = 1'b1;
      hold(10);
    end
    hold(10);
    chip_sel_n = 1'b1;
    hold(10);
    hoe = 1'b0;
  endtask : ser
endmodule : lhb_host_model
`default_nettype wire

// ### tb/tb_lhb_host_bus.sv
// self-checking bench for the host bus interface
`timescale 1ns/1ns
`default_nettype none
module tb_lhb_host_bus;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic init_low = 1'b1;
  logic ser_par_sel = 1'b1;
  logic strobe_mode = 1'b0;
  logic [7:0] rd_byte = 8'h5a;
  wire logic [7:0] data_in, data_out, rx_byte;
  wire logic data_oe, rd_pin, wr_pin, cmd_data_sel, chip_sel_n;
  wire logic rd_take, rx_is_data, rx_valid, init_active;
  int error_cnt = 0;
  int checked = 0;
  int rx_n = 0;
  int take_n = 0;
  logic [8:0] last = 9'h000;
  logic [7:0] seen;
  always #2 clk_sys = ~clk_sys;
  lhb_host_bus lhb_host_bus_i (.clk_sys, .srst, .data_in, .data_out, .data_oe,
    .rd_pin, .wr_pin, .cmd_data_sel, .chip_sel_n, .init_low, .ser_par_sel,
    .strobe_mode, .rd_byte, .rd_take, .rx_byte, .rx_is_data, .rx_valid, .init_active);
  lhb_host_model lhb_host_model_i (.clk_sys, .data_out, .data_oe, .strobe_mode,
    .data_in, .rd_pin, .wr_pin, .cmd_data_sel, .chip_sel_n);
  always @(posedge clk_sys) begin
    take_n += (rd_take === 1'b1);
    if (rx_valid === 1'b1) begin
      rx_n++;
      last = {rx_is_data, rx_byte};
    end
  end
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic t_split();
    lhb_host_model_i.wr(8'ha5, 1'b1, 1'b0);
    chk(last, 9'h1a5);
    lhb_host_model_i.wr(8'h3c, 1'b0, 1'b0);
    chk(last, 9'h03c);
    lhb_host_model_i.rd(1'b1, 1'b0, seen);
    chk(seen, 8'h5a);
    chk(take_n[8:0], 9'h001);
    chk(data_oe, 1'b0);
  endtask : t_split
  task automatic t_refuse();
    lhb_host_model_i.wr(8'h77, 1'b1, 1'b1);
    chk(rx_n[8:0], 9'h002);
    lhb_host_model_i.rd(1'b1, 1'b1, seen);
    chk(seen, 8'hff);
  endtask : t_refuse
  task automatic t_enable();
    strobe_mode = 1'b1;
    lhb_host_model_i.wr(8'hc3, 1'b1, 1'b0);
    chk(last, 9'h1c3);
    rd_byte = 8'h81;
    lhb_host_model_i.rd(1'b0, 1'b0, seen);
    chk(seen, 8'h81);
    chk(take_n[8:0], 9'h002);
  endtask : t_enable
  task automatic t_serial();
    ser_par_sel = 1'b0;
    lhb_host_model_i.ser(8'h96, 1'b1, 4);
    lhb_host_model_i.ser(8'h96, 1'b1, 8);
    chk(rx_n[8:0], 9'h004);
    chk(last, 9'h196);
    lhb_host_model_i.ser(8'h41, 1'b0, 8);
    chk(last, 9'h041);
  endtask : t_serial
  task automatic t_init();
    init_low = 1'b0;
    lhb_host_model_i.hold(6);
    chk(init_active, 1'b1);
    lhb_host_model_i.ser(8'h0f, 1'b1, 8);
    chk(rx_n[8:0], 9'h005);
    init_low = 1'b1;
    lhb_host_model_i.hold(6);
    chk(init_active, 1'b0);
    lhb_host_model_i.ser(8'h5c, 1'b0, 8);
    chk(rx_n[8:0], 9'h006);
    chk(last, 9'h05c);
  endtask : t_init
  initial begin
    lhb_host_model_i.hold(4);
    srst = 1'b0;
    lhb_host_model_i.hold(4);
    t_split();
    t_refuse();
    t_enable();
    t_serial();
    t_init();
    conclude();
  end
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule : tb_lhb_host_bus
`default_nettype wire
